// ---- logic/sram_cycle_pkg.sv ----
package sram_cycle_pkg;

  // ==========================================================
  // widths of the memory bus
  localparam int ADDR_W  = 21;
  localparam int DATA_W  = 40;
  localparam int BYTES   = 5;
  localparam int BURST_W = 2;

  // ==========================================================
  // write stream buffer toward the array
  localparam int FIFO_DEPTH = 4;
  // word layout: {address, byte mask, data}
  localparam int WDATA_LSB = 0;
  localparam int WMASK_LSB = DATA_W;
  localparam int WADDR_LSB = DATA_W + BYTES;
  localparam int WORD_W    = ADDR_W + BYTES + DATA_W;

  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 21'h000000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 40'h0000000000;
  localparam logic [BYTES-1:0]   MASK_RST  = 5'h1F;
  localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] COUNT_ONE = 2'h1;

  // ==========================================================
  // cycle currently in progress
  typedef enum logic [2:0] {
    ST_DESELECT,
    ST_READ,
    ST_WRITE,
    ST_DUMMY_WRITE,
    ST_SLEEP,
    ST_SHUTDOWN
  } cycle_type;

endpackage

// ---- logic/sram_write_fifo.sv ----
`timescale 1ns/1ps
module sram_write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire              push;
  wire              pop;

  // ==========================================================
  // handshakes; full and empty come from the occupancy count
  assign in_ready  = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // storage has no reset, only pointers and count do
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ---- logic/sync_sram_cycle_decode.sv ----
`timescale 1ns/1ps
module sync_sram_cycle_decode
  import sram_cycle_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              select_a_n,
  input  wire logic              select_b,
  input  wire logic              select_c_n,
  input  wire logic              clock_qualifier_n,
  input  wire logic              burst_step_or_load,
  input  wire logic              write_enable_n,
  input  wire logic [BYTES-1:0]  byte_write_mask_n,
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              shutdown,
  input  wire logic              burst_order,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  output logic                   device_ready,
  output logic                   sleep_active,
  output logic                   shutdown_active,
  output logic                   arr_rd_en,
  output logic      [ADDR_W-1:0] arr_rd_addr,
  input  wire logic [DATA_W-1:0] arr_rd_data,
  output logic                   arr_wr_valid,
  input  wire logic              arr_wr_ready,
  output logic      [ADDR_W-1:0] arr_wr_addr,
  output logic      [BYTES-1:0]  arr_wr_mask_n,
  output logic      [DATA_W-1:0] arr_wr_data
);

  // ==========================================================
  // state and registers
  cycle_type            state_reg;
  cycle_type            state_next;
  logic [ADDR_W-1:0]    base_reg;
  logic [BURST_W-1:0]   count_reg;
  logic                 order_reg;
  logic                 shut_meta_reg;
  logic                 shut_sync_reg;
  logic                 fetch_reg;
  logic                 fetch_hold_reg;
  logic [ADDR_W-1:0]    fetch_addr_reg;
  logic                 read_data_reg;
  logic [DATA_W-1:0]    dq_out_reg;
  logic                 wr_pend_reg;
  logic [ADDR_W-1:0]    wr_addr_reg;
  logic [BYTES-1:0]     wr_mask_reg;
  logic                 ready_reg;
  logic                 sleep_reg;
  logic                 shut_reg;

  // ==========================================================
  // burst address order
  // interleaved order is an xor of start and step, linear is a sum
  function automatic logic [BURST_W-1:0] burst_low(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] step,
    input logic               interleave
  );
    burst_low = interleave ? (start ^ step) : BURST_W'(start + step);
  endfunction

  // ==========================================================
  // decode of the pins sampled at this edge
  wire sel_all;
  wire stall;
  wire load;
  wire all_masked;
  wire busy_mode;
  wire start_ok;
  wire start_read;
  wire start_write;
  wire cont_cycle;

  // one inactive select is enough to deselect the group
  assign sel_all     = ~select_a_n & select_b & ~select_c_n;
  assign stall       = clock_qualifier_n;
  assign load        = ~burst_step_or_load;
  assign all_masked  = &byte_write_mask_n;
  assign busy_mode   = (state_reg == ST_SLEEP) | (state_reg == ST_SHUTDOWN);
  // sleep and shutdown must be low for any start
  assign start_ok    = ~stall & sel_all & load & ~sleep_request & ~shut_sync_reg;
  assign start_read  = start_ok & write_enable_n;
  assign start_write = start_ok & ~write_enable_n;
  assign cont_cycle  = ~stall & ~load & ~busy_mode;

  // ==========================================================
  // burst counter and address of this cycle
  wire [BURST_W-1:0] count_next;
  wire [ADDR_W-1:0]  base_next;
  wire [BURST_W-1:0] low_bits;
  wire [ADDR_W-1:0]  cycle_addr;
  wire               count_step;

  // step on every unstalled edge with step high
  // sleep and shutdown ignore the step pin, so the counter rests there
  assign count_step = cont_cycle;
  assign count_next = load ? COUNT_RST : BURST_W'(count_reg + COUNT_ONE);
  assign base_next  = load ? address : base_reg;
  // low two bits wrap inside the four-word block
  assign low_bits   = burst_low(base_next[BURST_W-1:0], count_next, order_reg);
  assign cycle_addr = {base_next[ADDR_W-1:BURST_W], low_bits};

  // ==========================================================
  // cycle type selection
  // shutdown outranks sleep, and sleep outranks the bus pins except the selects, of which at least one must be inactive
  always_comb begin
    state_next = state_reg;
    if (shut_sync_reg) begin
      state_next = ST_SHUTDOWN;
    end else begin
      case (state_reg)
        ST_SHUTDOWN: begin
          // contents are gone; only a reset leaves this mode
          state_next = ST_SHUTDOWN;
        end
        ST_SLEEP: begin
          // every other input and the clock qualifier are ignored
          if (!sleep_request) begin
            state_next = ST_DESELECT;
          end
        end
        ST_DESELECT,
        ST_READ,
        ST_WRITE,
        ST_DUMMY_WRITE: begin
          if (sleep_request && !sel_all) begin
            state_next = ST_SLEEP;
          end else if (stall) begin
            state_next = state_reg;
          end else if (load) begin
            if (start_read) begin
              state_next = ST_READ;
            end else if (start_write) begin
              state_next = all_masked ? ST_DUMMY_WRITE : ST_WRITE;
            end else begin
              state_next = ST_DESELECT;
            end
          end else begin
            case (state_reg)
              ST_READ: begin
                state_next = ST_READ;
              end
              ST_WRITE,
              ST_DUMMY_WRITE: begin
                // masks qualify each burst beat on its own
                state_next = all_masked ? ST_DUMMY_WRITE : ST_WRITE;
              end
              default: begin
                state_next = ST_DESELECT;
              end
            endcase
          end
        end
        default: begin
          state_next = ST_DESELECT;
        end
      endcase
    end
  end

  // ==========================================================
  // pending operations launched at this edge
  wire launch_read;
  wire launch_write;
  wire capture_ok;
  wire push_valid;
  wire push_ready;
  wire [WORD_W-1:0] push_word;
  wire [WORD_W-1:0] pop_word;

  assign launch_read  = ~stall & (state_next == ST_READ) & ~busy_mode;
  assign launch_write = ~stall & (state_next == ST_WRITE) & ~busy_mode;
  // write data arrive on the data lines one edge after the command
  assign capture_ok   = ~stall & ~shut_sync_reg;
  assign push_valid   = wr_pend_reg & capture_ok;
  assign push_word    = {wr_addr_reg, wr_mask_reg, dq_in};

  // ==========================================================
  // state, counter and burst order strap
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_DESELECT;
      base_reg  <= ADDR_RST;
      count_reg <= COUNT_RST;
      order_reg <= burst_order;
    end else begin
      state_reg <= state_next;
      if (!stall && !busy_mode && (start_read || start_write)) begin
        base_reg  <= address;
        count_reg <= COUNT_RST;
      end else if (count_step) begin
        count_reg <= count_next;
      end
    end
  end

  // shutdown pin is asynchronous; two flops before the state logic
  // the pin also cuts the drivers directly, further down
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shut_meta_reg <= 1'b0;
      shut_sync_reg <= 1'b0;
    end else begin
      shut_meta_reg <= shutdown;
      shut_sync_reg <= shut_meta_reg;
    end
  end

  // ==========================================================
  // read path: address out now, data back one edge later
  // a read issued just before a stall is still owed to the data lines;
  // the array holds its answer until the next read, so it is taken late
  wire fetch_owed;
  wire read_stays;

  assign fetch_owed = fetch_reg | fetch_hold_reg;
  assign read_stays = fetch_owed & (state_next == ST_READ);

  always_ff @(posedge mclk) begin
    if (sys_rst || shut_sync_reg) begin
      fetch_reg      <= 1'b0;
      fetch_hold_reg <= 1'b0;
      fetch_addr_reg <= ADDR_RST;
      read_data_reg  <= 1'b0;
      dq_out_reg     <= DATA_RST;
    end else if (!stall || busy_mode) begin
      // outside sleep and shutdown, a stalled edge leaves the data and drive state as they were
      fetch_reg      <= launch_read;
      fetch_hold_reg <= 1'b0;
      read_data_reg  <= read_stays;
      if (launch_read) begin
        fetch_addr_reg <= cycle_addr;
      end
      if (fetch_owed) begin
        dq_out_reg <= arr_rd_data;
      end
    end else begin
      // no new array read while stalled, but the owed one is remembered
      fetch_reg      <= 1'b0;
      fetch_hold_reg <= fetch_owed;
    end
  end

  // ==========================================================
  // write path: address and masks now, data at the next edge
  // a stalled edge keeps the pending beat for the next live edge
  always_ff @(posedge mclk) begin
    if (sys_rst || shut_sync_reg) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= ADDR_RST;
      wr_mask_reg <= MASK_RST;
    end else if (!stall) begin
      wr_pend_reg <= launch_write;
      if (launch_write) begin
        wr_addr_reg <= cycle_addr;
        wr_mask_reg <= byte_write_mask_n;
      end
    end
  end

  // the buffer absorbs array back-pressure; ready warns the controller
  // a beat offered while the buffer is full is lost, not held
  sram_write_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (arr_wr_valid),
    .out_ready (arr_wr_ready),
    .out_data  (pop_word)
  );

  // ==========================================================
  // status flops
  // ready follows the count before this edge's push, so it trails by one
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ready_reg <= 1'b0;
      sleep_reg <= 1'b0;
      shut_reg  <= 1'b0;
    end else begin
      ready_reg <= push_ready & ~shut_sync_reg;
      sleep_reg <= (state_next == ST_SLEEP);
      shut_reg  <= (state_next == ST_SHUTDOWN);
    end
  end

  // ==========================================================
  // data-line drive
  // the enable pin is not sampled so it reaches the drivers at once;
  // this is the one output with a path straight from the pins, a deliberate trade
  wire write_cycle;
  wire read_cycle;

  assign write_cycle = (state_reg == ST_WRITE) | (state_reg == ST_DUMMY_WRITE);
  assign read_cycle  = (state_reg == ST_READ) & read_data_reg;
  assign dq_oe       = read_cycle
                     & ~write_cycle
                     & ~output_enable_n
                     & ~shutdown;

  // ==========================================================
  // outputs
  assign dq_out          = dq_out_reg;
  assign device_ready    = ready_reg;
  assign sleep_active    = sleep_reg;
  assign shutdown_active = shut_reg;
  assign arr_rd_en       = fetch_reg;
  assign arr_rd_addr     = fetch_addr_reg;

  // write side shows the head word of the buffer
  assign arr_wr_addr     = pop_word[WADDR_LSB +: ADDR_W];
  assign arr_wr_mask_n   = pop_word[WMASK_LSB +: BYTES];
  assign arr_wr_data     = pop_word[WDATA_LSB +: DATA_W];

endmodule

// ---- dv/sync_sram_cycle_decode_props.sv ----
`timescale 1ns/1ps
// ==========================================================
// pin-level checker for the cycle decoder
module sram_cycle_props
  import sram_cycle_pkg::*;
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              select_a_n,
  input wire logic              select_b,
  input wire logic              select_c_n,
  input wire logic              clock_qualifier_n,
  input wire logic              burst_step_or_load,
  input wire logic              write_enable_n,
  input wire logic              output_enable_n,
  input wire logic              sleep_request,
  input wire logic              shutdown,
  input wire logic              burst_order,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe,
  input wire logic              sleep_active,
  input wire logic              shutdown_active,
  input wire logic              arr_rd_en,
  input wire logic [ADDR_W-1:0] arr_rd_addr
);
  // group selected, and an edge that may start or continue a cycle
  wire sel = !select_a_n && select_b && !select_c_n;
  wire go  = !clock_qualifier_n && !sleep_request && !shutdown
             && !sleep_active && !shutdown_active;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_shut_tristate: assert property (shutdown |-> !dq_oe)
    else $error("data lines driven during shutdown");
  chk_shut_latch: assert property (shutdown |-> ##[1:3] shutdown_active)
    else $error("shutdown state not reached");
  chk_oe_gate: assert property (output_enable_n |-> !dq_oe)
    else $error("data lines driven with output enable off");
  chk_read_start: assert property (go && !burst_step_or_load && sel && write_enable_n
    |=> arr_rd_en && arr_rd_addr == $past(address))
    else $error("read start did not fetch the loaded address");
  chk_write_float: assert property (go && !burst_step_or_load && sel && !write_enable_n
    |=> !dq_oe)
    else $error("data lines driven in a write cycle");
  chk_stall_hold: assert property (clock_qualifier_n && !sleep_request && !shutdown
    |=> !arr_rd_en && $stable(dq_out))
    else $error("stalled edge changed the read path");
  chk_standby_quiet: assert property (!clock_qualifier_n && !burst_step_or_load && !sel
    |=> !arr_rd_en && !dq_oe)
    else $error("deselected load started a cycle");
  chk_burst_upper: assert property (arr_rd_en && go && burst_step_or_load
    |=> arr_rd_en && arr_rd_addr[ADDR_W-1:2] == $past(arr_rd_addr[ADDR_W-1:2]))
    else $error("burst step lost the read or its upper address");
  chk_linear_step: assert property (arr_rd_en && go && burst_step_or_load && !burst_order
    |=> arr_rd_addr[1:0] == $past(arr_rd_addr[1:0]) + 2'h1)
    else $error("linear burst counter stepped wrongly");
  chk_sleep_entry: assert property (sleep_request && !sel && !shutdown && !shutdown_active
    |=> sleep_active && !dq_oe)
    else $error("sleep not entered while deselected");
endmodule

bind sync_sram_cycle_decode sram_cycle_props u_props (
  .mclk, .sys_rst, .select_a_n, .select_b, .select_c_n, .clock_qualifier_n,
  .burst_step_or_load, .write_enable_n, .output_enable_n, .sleep_request, .shutdown,
  .burst_order, .address, .dq_out, .dq_oe, .sleep_active, .shutdown_active,
  .arr_rd_en, .arr_rd_addr
);

// ---- dv/sram_ctrl_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// memory controller: drives the command pins and the write data
module sram_ctrl_model
  import sram_cycle_pkg::*;
(
  input  wire logic              mclk,
  output logic                   select_a_n,
  output logic                   select_b,
  output logic                   select_c_n,
  output logic                   clock_qualifier_n,
  output logic                   burst_step_or_load,
  output logic                   write_enable_n,
  output logic      [BYTES-1:0]  byte_write_mask_n,
  output logic      [ADDR_W-1:0] address,
  output logic      [DATA_W-1:0] dq_in
);
  // power-on state: deselected standby; the clock rate never changes here
  initial begin
    {select_a_n, select_b, select_c_n} = 3'h7;
    {clock_qualifier_n, burst_step_or_load, write_enable_n} = 3'h1;
    byte_write_mask_n = 5'h1F;
    address = 21'h000000;
    dq_in = 40'h0000000000;
  end

  // one bus cycle: change 1 ns after the edge, hold until the next edge
  // caller deselects before sleep and keeps wanted masks low per beat
  task automatic cyc(input logic [2:0] s, input logic q, input logic ld, input logic wen,
                     input logic [BYTES-1:0] m, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge mclk);
    #1;
    {select_a_n, select_b, select_c_n} = s;
    clock_qualifier_n = q;
    burst_step_or_load = ld;
    write_enable_n = wen;
    byte_write_mask_n = m;
    address = a;
    dq_in = d;
  endtask
endmodule

// ---- dv/test_sync_sram_cycle_decode.sv ----
`timescale 1ns/1ps
module test_sync_sram_cycle_decode
  import sram_cycle_pkg::*;
;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h7;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              output_enable_n = 1'b0;
  logic              sleep_request = 1'b0;
  logic              shutdown = 1'b0;
  logic              burst_order = 1'b0;
  logic              arr_wr_ready = 1'b0;
  wire logic         select_a_n, select_b, select_c_n, clock_qualifier_n;
  wire logic         burst_step_or_load, write_enable_n;
  wire logic [4:0]   byte_write_mask_n;
  wire logic [20:0]  address;
  wire logic [39:0]  dq_in;
  logic [DATA_W-1:0] dq_out, arr_rd_data, arr_wr_data;
  logic [ADDR_W-1:0] arr_rd_addr, arr_wr_addr;
  logic [BYTES-1:0]  arr_wr_mask_n;
  logic              dq_oe, device_ready, sleep_active, shutdown_active;
  logic              arr_rd_en, arr_wr_valid;
  int                checks = 0;
  int                miscompares = 0;

  always #20 mclk = ~mclk;

  sync_sram_cycle_decode dut (.mclk, .sys_rst, .select_a_n, .select_b, .select_c_n,
    .clock_qualifier_n, .burst_step_or_load, .write_enable_n, .byte_write_mask_n,
    .output_enable_n, .sleep_request, .shutdown, .burst_order, .address, .dq_in, .dq_out,
    .dq_oe, .device_ready, .sleep_active, .shutdown_active, .arr_rd_en, .arr_rd_addr,
    .arr_rd_data, .arr_wr_valid, .arr_wr_ready, .arr_wr_addr, .arr_wr_mask_n, .arr_wr_data);
  sram_ctrl_model ctrl (.mclk, .select_a_n, .select_b, .select_c_n, .clock_qualifier_n,
    .burst_step_or_load, .write_enable_n, .byte_write_mask_n, .address, .dq_in);

  // ==========================================================
  // array model: word content is a fixed scramble of its address
  function automatic logic [DATA_W-1:0] f(input logic [ADDR_W-1:0] a);
    return {a[18:0], a} ^ 40'hA5C30F963C;
  endfunction
  assign arr_rd_data = f(arr_rd_addr);

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // idle cycle: data lines released, so show a changing pattern
  task automatic idle;
    ctrl.cyc(DES, 1'b0, 1'b0, 1'b1, 5'h1F, 21'h0, ~dq_in);
  endtask

  task automatic do_reset(input logic order);
    @(posedge mclk);
    #1;
    sys_rst = 1'b1;
    burst_order = order;
    repeat (5) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    check(dq_oe, 1'b0);
    check(device_ready, 1'b0);
    idle;
    idle;
    check(device_ready, 1'b1);
    $display("test reset done");
  endtask

  // ==========================================================
  // every partial select pattern must leave the device idle
  task automatic t_selects;
    for (int s = 0; s < 8; s++) begin
      if (s[2:0] != SEL) begin
        ctrl.cyc(s[2:0], 1'b0, 1'b0, 1'b1, 5'h1F, 21'h7, ~dq_in);
        idle;
        check(arr_rd_en, 1'b0);
      end
    end
    ctrl.cyc(DES, 1'b0, 1'b1, 1'b1, 5'h1F, 21'h7, ~dq_in);
    idle;
    check(arr_rd_en, 1'b0);
    check(dq_oe, 1'b0);
    $display("test selects done");
  endtask

  // burst of four with a stall after the second step
  task automatic t_read(input logic order);
    logic [ADDR_W-1:0] a, e, prev;
    a = 21'h1234E;
    ctrl.cyc(SEL, 1'b0, 1'b0, 1'b1, 5'h1F, a, ~dq_in);
    for (int n = 0; n < 4; n++) begin
      ctrl.cyc(DES, 1'b0, n < 3, 1'b0, 5'h00, 21'h0, ~dq_in);
      e = {a[20:2], order ? a[1:0] ^ n[1:0] : a[1:0] + n[1:0]};
      check(arr_rd_addr, e);
      check(arr_rd_en, n != 2);
      if (n > 0) check(dq_out, f(prev));
      if (n > 0) check(dq_oe, 1'b1);
      if (n == 1) ctrl.cyc(DES, 1'b1, 1'b1, 1'b0, 5'h00, 21'h0, ~dq_in);
      if (n == 3) begin
        output_enable_n = 1'b1;
        #1 check(dq_oe, 1'b0);
        output_enable_n = 1'b0;
        #1 check(dq_oe, 1'b1);
      end
      prev = e;
    end
    idle;
    check(dq_out, f(prev));
    check(dq_oe, 1'b0);
    $display("test read done");
  endtask

  // write burst into a stalled buffer, then drain and compare
  task automatic t_write;
    logic [ADDR_W-1:0] a;
    logic [BYTES-1:0]  wm [4];
    a = 21'h0ABC5;
    wm = '{5'h00, 5'h15, 5'h0A, 5'h00};
    ctrl.cyc(SEL, 1'b0, 1'b0, 1'b0, wm[0], a, ~dq_in);
    for (int i = 1; i < 5; i++) begin
      ctrl.cyc(DES, 1'b0, i < 4, 1'b0, wm[i % 4], 21'h0, f(a + i - 1));
      check(dq_oe, 1'b0);
    end
    idle;
    // ready trails the last push by one edge
    idle;
    check(device_ready, 1'b0);
    for (int i = 0; i < 4; i++) begin
      check(arr_wr_addr, {a[20:2], a[1:0] + i[1:0]});
      check(arr_wr_mask_n, wm[i]);
      check(arr_wr_data, f(a + i));
      if (i == 0) arr_wr_ready = 1'b1;
      idle;
    end
    check(arr_wr_valid, 1'b0);
    arr_wr_ready = 1'b0;
    // all masks high: a dummy write stores nothing and keeps the lines off
    ctrl.cyc(SEL, 1'b0, 1'b0, 1'b0, 5'h1F, a, ~dq_in);
    idle;
    check(dq_oe, 1'b0);
    idle;
    check(arr_wr_valid, 1'b0);
    $display("test write done");
  endtask

  task automatic t_sleep;
    idle;
    sleep_request = 1'b1;
    idle;
    check(sleep_active, 1'b1);
    ctrl.cyc(SEL, 1'b0, 1'b0, 1'b1, 5'h1F, 21'h10, ~dq_in);
    idle;
    check(arr_rd_en, 1'b0);
    check(dq_oe, 1'b0);
    sleep_request = 1'b0;
    for (int k = 0; k < 8 && sleep_active !== 1'b0; k++) idle;
    check(sleep_active, 1'b0);
    idle;
    idle;
    $display("test sleep done");
  endtask

  // shutdown in the middle of a driven read burst
  task automatic t_shutdown;
    ctrl.cyc(SEL, 1'b0, 1'b0, 1'b1, 5'h1F, 21'h40, ~dq_in);
    ctrl.cyc(DES, 1'b0, 1'b1, 1'b1, 5'h1F, 21'h0, ~dq_in);
    ctrl.cyc(DES, 1'b0, 1'b1, 1'b1, 5'h1F, 21'h0, ~dq_in);
    check(dq_oe, 1'b1);
    shutdown = 1'b1;
    #1 check(dq_oe, 1'b0);
    repeat (3) idle;
    check(shutdown_active, 1'b1);
    shutdown = 1'b0;
    $display("test shutdown done");
  endtask

  // ==========================================================
  // main sequence; the second reset selects interleaved bursts
  initial begin
    do_reset(1'b0);
    t_selects;
    t_read(1'b0);
    t_write;
    t_sleep;
    t_shutdown;
    do_reset(1'b1);
    t_read(1'b1);
    end_sim;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #400000;
    miscompares++;
    $display("watchdog expired");
    end_sim;
  end
endmodule
